//--- test/tsg_pad_model.sv
`timescale 1ns/1ps
module tsg_pad_model
(
   input wire logic clock,
   input wire logic [7:0] padOut,
   input wire logic [7:0] padOe,
   input wire logic [7:0] pullOn,
   input wire logic [7:0] extEn,
   input wire logic [7:0] ext,
   output logic [7:0] padIn
);
   logic flip = 1'b0;
   // Undriven unpulled pads wander, so reading one cannot match by luck
   always_ff @(posedge clock)
      flip <= ~flip;
   assign padIn = (padOe & padOut) | (~padOe & extEn & ext)
      | (~padOe & ~extEn & (pullOn | {8{flip}}));
endmodule

//--- test/tsg_tb.sv
`timescale 1ns/1ps
`include "tsg_cfg.svh"
module tb;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWdata = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic regRmw = 1'b0;
   logic hiz = 1'b0;
   logic stopWatch = 1'b0;
   logic touchStop = 1'b0;
   logic irqEn = 1'b0;
   logic [7:0] poe [2] = '{2{8'h00}}, pout [2] = '{2{8'h00}};
   logic [7:0] ext [2] = '{2{8'h00}}, pull [2] = '{2{8'h00}};
   logic [7:0] dir [2], lat [2], padIn [2], padOut [2], padOe [2], pullOn [2], portIn [2];
   logic [7:0] msk [2] = '{`TSG_P6_MASK, `TSG_P7_MASK};
   logic [7:0] regRdata, touchIn;
   logic touchRefIn, timerIn;
   logic [31:0] seed = 32'h793d;
   int badCount = 0;
   int nCompared = 0;
   int cyc = 0;

   touch_shared_gpio_ports u_dut
   (
      .clock(clock), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRmw(regRmw), .regRdata(regRdata),
      .standbyPinHizSelect(hiz), .standbyStopWatch(stopWatch),
      .touchStopEnable(touchStop), .extIrqCh0Enable(irqEn),
      .p6PeriphOe(poe[0]), .p6PeriphOut(pout[0]), .p7PeriphOe(poe[1]),
      .p7PeriphOut(pout[1]), .p6PadIn(padIn[0]), .p7PadIn(padIn[1]),
      .p6PadOut(padOut[0]), .p6PadOe(padOe[0]), .p6PullOn(pullOn[0]),
      .p7PadOut(padOut[1]), .p7PadOe(padOe[1]), .p7PullOn(pullOn[1]),
      .p6PortIn(portIn[0]), .p7PortIn(portIn[1]), .touchIn(touchIn),
      .touchRefIn(touchRefIn), .timer1ClockIn(timerIn)
   );

   for (genvar g = 0; g < 2; g++)
   begin : g_pad
      tsg_pad_model u_pad (.clock(clock), .padOut(padOut[g]), .padOe(padOe[g]),
         .pullOn(pullOn[g]), .extEn(~pull[g]), .ext(ext[g]), .padIn(padIn[g]));
   end

   initial
   begin
      forever #20 clock = ~clock;
   end

   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   function automatic logic [7:0] drv(input int p);
      return (poe[p] & pout[p]) | (~poe[p] & lat[p]);
   endfunction

   // Level on the pad as the far side sees it; pulled pads are left undriven and read high
   function automatic logic [7:0] lvl(input int p);
      logic [7:0] oe;
      oe = dir[p] | poe[p];
      return (oe & drv(p)) | (~oe & (pull[p] | ext[p]));
   endfunction

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      nCompared++;
      if (seen !== exp)
      begin
         badCount++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clock);
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'b1;
      @(posedge clock);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, input logic m, output logic [7:0] v);
      @(posedge clock);
      regAddr <= a;
      regRd <= 1'b1;
      regRmw <= m;
      @(posedge clock);
      regRd <= 1'b0;
      regRmw <= 1'b0;
      #1;
      v = regRdata;
   endtask

   task automatic reportAndStop();
      $display("compared %0d mismatches %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         badCount++;
         reportAndStop();
      end
   end

   initial
   begin
      logic [7:0] d, tA, tB, tm;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      repeat (3) @(posedge clock);
      for (int a = 0; a < 8; a++)
      begin
         rd(3'(a), 1'b0, d);
         if (a % 4 != 0)
         begin
            chk(d, 8'h00);
            wr(3'(a), 8'hff);
            rd(3'(a), 1'b0, d);
            chk(d, a == 3 ? `TSG_TIDA_MASK : msk[a / 4]);
         end
         else
            chk(d, 8'h00);
      end
      for (int i = 0; i < 40; i++)
      begin
         for (int p = 0; p < 2; p++)
         begin
            dir[p] = rnd();
            lat[p] = rnd();
            d = rnd();
            wr(3'(p * 4 + 1), dir[p]);
            wr(3'(p * 4), lat[p]);
            wr(3'(p * 4 + 2), d);
            pull[p] <= d;
            ext[p] <= rnd();
            poe[p] <= (i % 4 == 3) ? rnd() : 8'h00;
            pout[p] <= rnd();
         end
         repeat (3) @(posedge clock);
         for (int p = 0; p < 2; p++)
         begin
            rd(3'(p * 4), 1'b0, d);
            chk(d, msk[p] & lvl(p));
            rd(3'(p * 4), 1'b1, d);
            chk(d, msk[p] & lat[p]);
            chk(padOe[p], msk[p] & (dir[p] | poe[p]));
            chk(padOut[p] & padOe[p], msk[p] & (dir[p] | poe[p]) & drv(p));
            chk(pullOn[p], msk[p] & pull[p] & ~((dir[p] | poe[p]) & ~drv(p)));
            chk(portIn[p], msk[p] & lvl(p));
         end
      end
      @(posedge clock);
      rstn <= 1'b0;
      poe <= '{2{8'h00}};
      pull <= '{2{8'h00}};
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      repeat (3) @(posedge clock);
      chk(padOe[0] | padOe[1], 8'h00);
      rd(`TSG_A_P7_DIR, 1'b0, d);
      chk(d, 8'h00);
      for (int j = 0; j < 4; j++)
      begin
         tA = rnd() & `TSG_TIDA_MASK;
         tB = rnd() & `TSG_TIDB_MASK;
         wr(`TSG_A_TID_A, tA);
         wr(`TSG_A_TID_B, tB);
         ext[0] <= rnd();
         ext[1] <= rnd();
         repeat (3) @(posedge clock);
         tm = ~{tB[3:0], tA[3:0]};
         chk(portIn[0], {tA[3:0], tA[4], 3'b001} & ext[0]);
         chk(portIn[1], tB & ext[1]);
         chk(touchIn, tm & {ext[1][3:0], ext[0][7:4]});
         chk({7'h00, touchRefIn}, {7'h00, ext[0][3] & ~tA[4]});
      end
      wr(`TSG_A_P6_DIR, 8'hff);
      wr(`TSG_A_P7_DIR, 8'hff);
      for (int k = 0; k < 4; k++)
      begin
         @(posedge clock);
         hiz <= 1'b1;
         stopWatch <= 1'b1;
         irqEn <= k[0];
         touchStop <= k[1];
         repeat (3) @(posedge clock);
         chk(padOe[0] | padOe[1], 8'h00);
         chk(portIn[0] | portIn[1], {7'h00, k[0] & ext[0][0]});
         chk({7'h00, timerIn}, {7'h00, k[0] & ext[0][0]});
         chk(touchIn, k[1] ? tm & {ext[1][3:0], ext[0][7:4]} : 8'h00);
         hiz <= 1'b0;
         repeat (3) @(posedge clock);
         chk(padOe[0], `TSG_P6_MASK);
         chk(padOe[1], `TSG_P7_MASK);
      end
      reportAndStop();
   end
endmodule

//--- verilog/touch_shared_gpio_ports.sv
// Operation
// - Direction one drives latch onto pin
// - Direction zero leaves pin undriven input
// - Writes always update latch, outputs show it
// - Output pin read returns latch
// - Input read returns pin, RMW returns latch
// - Peripheral output enable replaces latch on pin
// - Peripheral output read returns pin level
// - Read returns pin regardless peripheral input use
// - Reset clears all direction bits
// - Standby hi-z forces pins off, inputs low
// - Timer pin input kept if irq enabled
// - Touch inputs kept when touch stop-enabled
// - Standby select zero keeps pin states
// - Touch-disable zero selects touch path
// - Pull bit one connects pull-up
// - Driving low disconnects pull-up
// - Port and touch-disable bit maps
`timescale 1ns/1ps
`include "tsg_cfg.svh"
module touch_shared_gpio_ports
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic [2:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic regRmw,
   output logic [7:0] regRdata,
   input wire logic standbyPinHizSelect,
   input wire logic standbyStopWatch,
   input wire logic touchStopEnable,
   input wire logic extIrqCh0Enable,
   input wire logic [7:0] p6PeriphOe,
   input wire logic [7:0] p6PeriphOut,
   input wire logic [7:0] p7PeriphOe,
   input wire logic [7:0] p7PeriphOut,
   input wire logic [7:0] p6PadIn,
   input wire logic [7:0] p7PadIn,
   output logic [7:0] p6PadOut,
   output logic [7:0] p6PadOe,
   output logic [7:0] p6PullOn,
   output logic [7:0] p7PadOut,
   output logic [7:0] p7PadOe,
   output logic [7:0] p7PullOn,
   output logic [7:0] p6PortIn,
   output logic [7:0] p7PortIn,
   output logic [7:0] touchIn,
   output logic touchRefIn,
   output logic timer1ClockIn
);
   typedef struct packed {
      tsg_pkg::tsg_byte_t p6Data;
      tsg_pkg::tsg_byte_t p6Dir;
      tsg_pkg::tsg_byte_t p6Pull;
      tsg_pkg::tsg_byte_t tidA;
      tsg_pkg::tsg_byte_t p7Data;
      tsg_pkg::tsg_byte_t p7Dir;
      tsg_pkg::tsg_byte_t p7Pull;
      tsg_pkg::tsg_byte_t tidB;
      tsg_pkg::tsg_byte_t rdata;
      tsg_pkg::tsg_byte_t p6Out;
      tsg_pkg::tsg_byte_t p6Oe;
      tsg_pkg::tsg_byte_t p6Pu;
      tsg_pkg::tsg_byte_t p7Out;
      tsg_pkg::tsg_byte_t p7Oe;
      tsg_pkg::tsg_byte_t p7Pu;
      tsg_pkg::tsg_byte_t p6In;
      tsg_pkg::tsg_byte_t p7In;
      tsg_pkg::tsg_byte_t touch;
      logic ref_;
      logic tmr;
   } tsg_state_s;

   tsg_state_s state_ff;
   tsg_state_s nxt_state;
   logic rstSync1_ff;
   logic rstSync2_ff;
   logic [7:0] wrSel;
   logic [7:0] rdSel;
   logic [7:0] c6Out, c6Oe, c6Pu, c6In;
   logic [7:0] c7Out, c7Oe, c7Pu, c7In;
   logic [7:0] keep6, keep7;
   logic [7:0] tid6;
   logic forceHiz;
   logic [7:0] p6OeMasked, p7OeMasked;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         rstSync1_ff <= 1'b0;
         rstSync2_ff <= 1'b0;
      end
      else
      begin
         rstSync1_ff <= 1'b1;
         rstSync2_ff <= rstSync1_ff;
      end
   end

   tsg_bus_if u_bus
   (
      .addr(regAddr),
      .wrSel(wrSel),
      .rdSel(rdSel),
      .wrStb(regWr),
      .rdStb(regRd)
   );

   // Touch-disable bits per port-6 pin: pins 7..3 use bits 3,2,1,0,4
   assign tid6 = {state_ff.tidA[3:0], state_ff.tidA[4], 3'h0};
   assign forceHiz = standbyPinHizSelect & standbyStopWatch;
   assign p6OeMasked = p6PeriphOe & `TSG_P6_MASK;
   assign p7OeMasked = p7PeriphOe & `TSG_P7_MASK;

   // Inputs that must keep working through standby
   always_comb
   begin
      // Only touch-path pins with touch stop enabled and, with the irq enabled, the timer pin stay open; other port inputs keep their clamp
      keep6 = touchStopEnable ? (~tid6 & 8'hf8) : 8'h00;
      keep6[`TSG_TIMER_PIN] = extIrqCh0Enable;
      keep7 = touchStopEnable ? (~state_ff.tidB & 8'h0f) : 8'h00;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1)
      begin : g_pin
         tsg_pin_cell u_p6
         (
            .dirBit(state_ff.p6Dir[gi]),
            .latchBit(state_ff.p6Data[gi]),
            .periphOe(p6OeMasked[gi]),
            .periphOut(p6PeriphOut[gi]),
            .pullBit(state_ff.p6Pull[gi]),
            .padIn(p6PadIn[gi]),
            .forceHiz(forceHiz),
            .keepInput(keep6[gi]),
            .drvOut(c6Out[gi]),
            .drvOe(c6Oe[gi]),
            .pullOn(c6Pu[gi]),
            .inGated(c6In[gi])
         );
         tsg_pin_cell u_p7
         (
            .dirBit(state_ff.p7Dir[gi]),
            .latchBit(state_ff.p7Data[gi]),
            .periphOe(p7OeMasked[gi]),
            .periphOut(p7PeriphOut[gi]),
            .pullBit(state_ff.p7Pull[gi]),
            .padIn(p7PadIn[gi]),
            .forceHiz(forceHiz),
            .keepInput(keep7[gi]),
            .drvOut(c7Out[gi]),
            .drvOe(c7Oe[gi]),
            .pullOn(c7Pu[gi]),
            .inGated(c7In[gi])
         );
      end
   endgenerate

   always_comb
   begin
      nxt_state = state_ff;
      // Latches take every write whatever the direction
      if (wrSel[`TSG_A_P6_DATA])
         nxt_state.p6Data = regWdata & `TSG_P6_MASK;
      if (wrSel[`TSG_A_P6_DIR])
         nxt_state.p6Dir = regWdata & `TSG_P6_MASK;
      if (wrSel[`TSG_A_P6_PULL])
         nxt_state.p6Pull = regWdata & `TSG_P6_MASK;
      if (wrSel[`TSG_A_TID_A])
         nxt_state.tidA = regWdata & `TSG_TIDA_MASK;
      if (wrSel[`TSG_A_P7_DATA])
         nxt_state.p7Data = regWdata & `TSG_P7_MASK;
      if (wrSel[`TSG_A_P7_DIR])
         nxt_state.p7Dir = regWdata & `TSG_P7_MASK;
      if (wrSel[`TSG_A_P7_PULL])
         nxt_state.p7Pull = regWdata & `TSG_P7_MASK;
      if (wrSel[`TSG_A_TID_B])
         nxt_state.tidB = regWdata & `TSG_TIDB_MASK;

      // Read data stands only in the cycle after the strobe
      nxt_state.rdata = 8'h00;
      if (rdSel[`TSG_A_P6_DATA])
      begin
         // Output-only bits show the latch; peripheral-driven or input bits show the pad
         if (regRmw)
            nxt_state.rdata = state_ff.p6Data;
         else
            nxt_state.rdata = ((state_ff.p6Data & state_ff.p6Dir & ~p6PeriphOe)
               | (c6In & ~(state_ff.p6Dir & ~p6PeriphOe))) & `TSG_P6_MASK;
      end
      if (rdSel[`TSG_A_P6_DIR])
         nxt_state.rdata = state_ff.p6Dir;
      if (rdSel[`TSG_A_P6_PULL])
         nxt_state.rdata = state_ff.p6Pull;
      if (rdSel[`TSG_A_TID_A])
         nxt_state.rdata = state_ff.tidA;
      if (rdSel[`TSG_A_P7_DATA])
      begin
         if (regRmw)
            nxt_state.rdata = state_ff.p7Data;
         else
            nxt_state.rdata = ((state_ff.p7Data & state_ff.p7Dir & ~p7PeriphOe)
               | (c7In & ~(state_ff.p7Dir & ~p7PeriphOe))) & `TSG_P7_MASK;
      end
      if (rdSel[`TSG_A_P7_DIR])
         nxt_state.rdata = state_ff.p7Dir;
      if (rdSel[`TSG_A_P7_PULL])
         nxt_state.rdata = state_ff.p7Pull;
      if (rdSel[`TSG_A_TID_B])
         nxt_state.rdata = state_ff.tidB;

      nxt_state.p6Out = c6Out & `TSG_P6_MASK;
      nxt_state.p6Oe = c6Oe & `TSG_P6_MASK;
      nxt_state.p6Pu = c6Pu & `TSG_P6_MASK;
      nxt_state.p7Out = c7Out & `TSG_P7_MASK;
      nxt_state.p7Oe = c7Oe & `TSG_P7_MASK;
      nxt_state.p7Pu = c7Pu & `TSG_P7_MASK;
      // Digital input path is open only when touch-disable is set, except port-6 pin 0 which is always open
      nxt_state.p6In = c6In & (tid6 | 8'h01) & `TSG_P6_MASK;
      nxt_state.p7In = c7In & state_ff.tidB & `TSG_P7_MASK;
      nxt_state.touch = {c7In[3:0] & ~state_ff.tidB[3:0],
         c6In[7:4] & ~tid6[7:4]};
      nxt_state.ref_ = c6In[`TSG_REF_PIN] & ~tid6[`TSG_REF_PIN];
      // Timer clock sees the pad whenever its input is not blocked
      nxt_state.tmr = c6In[`TSG_TIMER_PIN];
   end

   always_ff @(posedge clock or negedge rstSync2_ff)
   begin
      if (!rstSync2_ff)
      begin
         state_ff <= '0;
         state_ff.p6Dir <= `TSG_DIR_RST;
         state_ff.p7Dir <= `TSG_DIR_RST;
      end
      else
         state_ff <= nxt_state;
   end

   assign regRdata = state_ff.rdata;
   assign p6PadOut = state_ff.p6Out;
   assign p6PadOe = state_ff.p6Oe;
   assign p6PullOn = state_ff.p6Pu;
   assign p7PadOut = state_ff.p7Out;
   assign p7PadOe = state_ff.p7Oe;
   assign p7PullOn = state_ff.p7Pu;
   assign p6PortIn = state_ff.p6In;
   assign p7PortIn = state_ff.p7In;
   assign touchIn = state_ff.touch;
   assign touchRefIn = state_ff.ref_;
   assign timer1ClockIn = state_ff.tmr;

   property p_out_drive;
      @(posedge clock) disable iff (!rstSync2_ff)
      (state_ff.p6Dir[7] && !p6PeriphOe[7] && !forceHiz)
         |=> (p6PadOe[7] && p6PadOut[7] == $past(state_ff.p6Data[7]));
   endproperty
   a_out_drive: assert property (p_out_drive) else $error("output pin not driving latch");

   property p_in_release;
      @(posedge clock) disable iff (!rstSync2_ff)
      (!state_ff.p7Dir[0] && !p7PeriphOe[0]) |=> !p7PadOe[0];
   endproperty
   a_in_release: assert property (p_in_release) else $error("input pin driven");

   property p_wr_latch;
      @(posedge clock) disable iff (!rstSync2_ff)
      (regWr && regAddr == `TSG_A_P7_DATA) |=> state_ff.p7Data == ($past(regWdata) & `TSG_P7_MASK);
   endproperty
   a_wr_latch: assert property (p_wr_latch) else $error("latch not updated");

   property p_rmw_read;
      @(posedge clock) disable iff (!rstSync2_ff)
      (regRd && regRmw && regAddr == `TSG_A_P6_DATA) |=> regRdata == $past(state_ff.p6Data);
   endproperty
   a_rmw_read: assert property (p_rmw_read) else $error("rmw read not latch");

   property p_periph_route;
      @(posedge clock) disable iff (!rstSync2_ff)
      (p6PeriphOe[0] && !forceHiz) |=> (p6PadOe[0] && p6PadOut[0] == $past(p6PeriphOut[0]));
   endproperty
   a_periph_route: assert property (p_periph_route) else $error("peripheral not routed");

   property p_hiz;
      @(posedge clock) disable iff (!rstSync2_ff)
      forceHiz |=> (p6PadOe == 8'h00 && p7PadOe == 8'h00);
   endproperty
   a_hiz: assert property (p_hiz) else $error("pin driven in standby");

   property p_touch_keep;
      @(posedge clock) disable iff (!rstSync2_ff)
      (forceHiz && touchStopEnable && !state_ff.tidB[2]) |=> touchIn[6] == $past(p7PadIn[2]);
   endproperty
   a_touch_keep: assert property (p_touch_keep) else $error("touch input blocked");

   property p_pull_low;
      @(posedge clock) disable iff (!rstSync2_ff)
      (p7PadOe[1] && !p7PadOut[1]) |-> !p7PullOn[1];
   endproperty
   a_pull_low: assert property (p_pull_low) else $error("pull-up on while driving low");

   property p_in_read;
      @(posedge clock) disable iff (!rstSync2_ff)
      (regRd && !regRmw && regAddr == `TSG_A_P7_DATA && !state_ff.p7Dir[0] && !forceHiz)
         |=> regRdata[0] == $past(p7PadIn[0]);
   endproperty
   a_in_read: assert property (p_in_read) else $error("input pin read not pad");

   property p_periph_read;
      @(posedge clock) disable iff (!rstSync2_ff)
      (regRd && !regRmw && regAddr == `TSG_A_P6_DATA && p6PeriphOe[0] && !forceHiz)
         |=> regRdata[0] == $past(p6PadIn[0]);
   endproperty
   a_periph_read: assert property (p_periph_read) else $error("peripheral pin read not pad");

   property p_hiz_block;
      @(posedge clock) disable iff (!rstSync2_ff)
      (forceHiz && !extIrqCh0Enable && !touchStopEnable)
         |=> (p6PortIn == 8'h00 && p7PortIn == 8'h00 && touchIn == 8'h00
         && !timer1ClockIn && !touchRefIn);
   endproperty
   a_hiz_block: assert property (p_hiz_block) else $error("input not clamped in standby");

   property p_timer_keep;
      @(posedge clock) disable iff (!rstSync2_ff)
      (forceHiz && extIrqCh0Enable) |=> timer1ClockIn == $past(p6PadIn[0]);
   endproperty
   a_timer_keep: assert property (p_timer_keep) else $error("timer input blocked");

   property p_level_hold;
      @(posedge clock) disable iff (!rstSync2_ff)
      (!standbyPinHizSelect && state_ff.p6Dir[3] && !p6PeriphOe[3])
         |=> (p6PadOe[3] && p6PadOut[3] == $past(state_ff.p6Data[3]));
   endproperty
   a_level_hold: assert property (p_level_hold) else $error("output level not held");

   property p_tid_route;
      @(posedge clock) disable iff (!rstSync2_ff)
      (!forceHiz && state_ff.tidB[1]) |=> (p7PortIn[1] == $past(p7PadIn[1]) && !touchIn[5]);
   endproperty
   a_tid_route: assert property (p_tid_route) else $error("touch-disable routing wrong");

   property p_pull_on;
      @(posedge clock) disable iff (!rstSync2_ff)
      (state_ff.p7Pull[3] && !state_ff.p7Dir[3] && !p7PeriphOe[3] && !forceHiz)
         |=> p7PullOn[3];
   endproperty
   a_pull_on: assert property (p_pull_on) else $error("pull-up not connected");
endmodule

//--- verilog/tsg_bus_if.sv
`timescale 1ns/1ps
// Register port decode; read data ready one cycle after the strobe
module tsg_bus_if
(
   input wire logic [2:0] addr,
   input wire logic wrStb,
   input wire logic rdStb,
   output logic [7:0] wrSel,
   output logic [7:0] rdSel
);
   always_comb
   begin
      wrSel = 8'h00;
      rdSel = 8'h00;
      wrSel[addr] = wrStb;
      rdSel[addr] = rdStb;
   end
endmodule

//--- verilog/tsg_cfg.svh
`ifndef TSG_CFG_SVH
`define TSG_CFG_SVH
// Register indices on the plain register port
`define TSG_ADDR_W 3
`define TSG_A_P6_DATA 3'h0
`define TSG_A_P6_DIR 3'h1
`define TSG_A_P6_PULL 3'h2
`define TSG_A_TID_A 3'h3
`define TSG_A_P7_DATA 3'h4
`define TSG_A_P7_DIR 3'h5
`define TSG_A_P7_PULL 3'h6
`define TSG_A_TID_B 3'h7
// Implemented bits
`define TSG_P6_MASK 8'hf9
`define TSG_P7_MASK 8'h0f
`define TSG_TIDA_MASK 8'h1f
`define TSG_TIDB_MASK 8'h0f
// Reset values
`define TSG_DIR_RST 8'h00
`define TSG_DATA_RST 8'h00
`define TSG_PULL_RST 8'h00
`define TSG_TID_RST 8'h00
// Field positions
`define TSG_TIMER_PIN 0
`define TSG_REF_PIN 3
`endif

//--- verilog/tsg_pin_cell.sv
`timescale 1ns/1ps
// One pad's combinational steering: output mux, enable, pull-up and input gate
module tsg_pin_cell
(
   input wire logic dirBit,
   input wire logic latchBit,
   input wire logic periphOe,
   input wire logic periphOut,
   input wire logic pullBit,
   input wire logic padIn,
   input wire logic forceHiz,
   input wire logic keepInput,
   output logic drvOut,
   output logic drvOe,
   output logic pullOn,
   output logic inGated
);
   always_comb
   begin
      drvOut = periphOe ? periphOut : latchBit;
      drvOe = (periphOe | dirBit) & ~forceHiz;
      // A pad driving low must never fight its own pull-up
      pullOn = pullBit & ~(drvOe & ~drvOut) & ~forceHiz;
      inGated = padIn & (~forceHiz | keepInput);
   end
endmodule

//--- verilog/tsg_pkg.sv
package tsg_pkg;
   typedef logic [7:0] tsg_byte_t;
endpackage
